// [design/lpl_lane_test.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Each lane has a shift-register pattern generator paired with a checker.
// - Generator emits a fixed repeating sequence, ones and zeros equally likely.
// - Wide buses offer the 31-stage pattern, taps 31 and 28.
// - Wide buses offer the 23-stage pattern, taps 23 and 18.
// - Wide buses offer the 15-stage pattern, taps 15 and 14.
// - Wide buses offer the 9-stage pattern, taps 9 and 5.
// - Wide buses offer the 7-stage pattern, taps 7 and 6.
// - Buses of 8, 10, 16 or 20 bits carry only the 7-stage pattern.
// - Checker compares deserialized receive words against the expected sequence.
// - A word slip during a test makes the next word mismatch; avoid slipping.
// - Three selectable loopback paths isolate link segments.
// - Equalizer far loopback sends received serial data out, bypassing equalizers.
// - Equalizer far loopback skips clock recovery; no rate relation to transmit.
// - Equalizer near loopback feeds serial transmit data to clock recovery only.
// - Recovered-clock far loopback passes received words through a loopback FIFO.
// - Words from that FIFO are serialized and transmitted to the far end.
module lpl_lane_test #(
    parameter int DATA_W = 40,
    parameter int LB_DEPTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DATA_W-1:0] tx_user_data,
    output logic [DATA_W-1:0] tx_word,
    input wire logic [DATA_W-1:0] rx_word,
    input wire logic rx_word_valid,
    input wire logic rx_path_ready,
    input wire logic rx_word_boundary_shift,
    output logic [DATA_W-1:0] rx_user_data,
    output logic rx_word_qualified,
    output logic equalizer_far_loopback,
    output logic equalizer_near_loopback,
    output logic recovered_clock_far_loopback,
    output logic eq_bypass,
    output logic cdr_bypass,
    output logic tx_driver_en,
    output logic test_error
);
    import lpl_pkg::*;

    localparam int PW = $clog2(LB_DEPTH);
    localparam logic [PW:0] LB_HALF = (PW+1)'(LB_DEPTH / 2);
    localparam logic [PW:0] LB_FULL = (PW+1)'(LB_DEPTH);
    localparam logic [LPL_CNT_W-1:0] CNT_MAX = '1;

    logic [6:0] ctrl_q;
    logic err_flag_q;
    logic drift_q;
    logic [LPL_CNT_W-1:0] cnt_q;
    logic [DATA_W-1:0] tx_word_q;
    logic [DATA_W-1:0] rx_user_q;
    logic rx_qual_q;
    logic [1:0] sync_q;
    logic [DATA_W-1:0] lb_mem [LB_DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] fill_q;
    logic lb_run_q;
    logic slip_seen_q;
    logic slip_err_q;

    // APB decode, zero wait states
    wire logic acc = psel && penable;
    wire logic wr_en = acc && pwrite;
    wire logic hit_ctrl = (paddr == LPL_ADDR_CTRL);
    wire logic hit_stat = (paddr == LPL_ADDR_STATUS);
    wire logic hit_cnt = (paddr == LPL_ADDR_ERRCNT);
    wire logic hit_any = hit_ctrl || hit_stat || hit_cnt;
    wire logic ctrl_wr = wr_en && hit_ctrl;
    wire logic err_clr = wr_en && hit_stat && pwdata[LPL_STAT_ERR_BIT];
    wire logic drift_clr = wr_en && hit_stat && pwdata[LPL_STAT_DRIFT_BIT];
    wire logic cnt_clr = wr_en && hit_cnt;

    wire logic gen_en = ctrl_q[LPL_CTRL_GEN_BIT];
    wire logic chk_en = ctrl_q[LPL_CTRL_CHK_BIT];
    wire logic [2:0] pat_sel = ctrl_q[LPL_CTRL_PAT_LSB +: 3];
    wire logic [1:0] lb_sel = ctrl_q[LPL_CTRL_LB_LSB +: 2];

    // Narrow buses fall back to the 7-stage pattern; unknown codes do too
    wire logic wide = (DATA_W >= LPL_WIDE_MIN);
    wire logic pat_ok = (pat_sel == LPL_PAT_31) || (pat_sel == LPL_PAT_23)
        || (pat_sel == LPL_PAT_15) || (pat_sel == LPL_PAT_9);
    wire logic [2:0] pat_eff = (wide && pat_ok) ? pat_sel : LPL_PAT_7;

    // Loopback decode: one code, so at most one path can be on
    wire logic lb_eqf = (lb_sel == LPL_LB_EQ_FAR);
    wire logic lb_eqn = (lb_sel == LPL_LB_EQ_NEAR);
    wire logic lb_cdr = (lb_sel == LPL_LB_CDR_FAR);

    assign equalizer_far_loopback = lb_eqf;
    assign equalizer_near_loopback = lb_eqn;
    assign recovered_clock_far_loopback = lb_cdr;
    assign eq_bypass = lb_eqf;
    assign cdr_bypass = lb_eqf;
    assign tx_driver_en = !lb_eqn;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= LPL_CTRL_RESET;
        end
        else if (ctrl_wr)
        begin
            ctrl_q <= pwdata[6:0];
        end
    end

    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;
    assign prdata = !hit_any ? 32'h00000000
        : hit_ctrl ? {25'h0000000, ctrl_q}
        : hit_stat ? {30'h00000000, drift_q, err_flag_q}
        : {16'h0000, cnt_q};

    // Generator and checker
    logic [DATA_W-1:0] gen_word;
    logic chk_mis;

    lpl_prbs_word #(
        .W(DATA_W)
    ) u_gen (
        .clock(clock),
        .nrst(nrst),
        .pat(pat_eff),
        .run(gen_en),
        .chk_mode(1'b0),
        .din('0),
        .dout(gen_word),
        .mismatch()
    );

    // Checker history follows the received stream, so a slipped boundary
    // breaks the prediction for the word after the slip
    lpl_prbs_word #(
        .W(DATA_W)
    ) u_chk (
        .clock(clock),
        .nrst(nrst),
        .pat(pat_eff),
        .run(chk_en && rx_word_valid),
        .chk_mode(1'b1),
        .din(rx_word),
        .dout(),
        .mismatch(chk_mis)
    );

    // Ignore the first words while the history fills
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_q <= 2'h0;
        end
        else if (!chk_en)
        begin
            sync_q <= 2'h0;
        end
        else if (rx_word_valid && sync_q != LPL_SYNC_WORDS)
        begin
            sync_q <= sync_q + 2'h1;
        end
    end

    // A slip is flagged on the next word even if its bits happen to fit,
    // since a shifted pattern can briefly still look valid
    wire logic slip_seen_d = chk_en && (rx_word_boundary_shift
        || (slip_seen_q && !rx_word_valid));

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            slip_seen_q <= 1'b0;
            slip_err_q <= 1'b0;
        end
        else
        begin
            slip_seen_q <= slip_seen_d;
            slip_err_q <= chk_en && rx_word_valid && slip_seen_q;
        end
    end

    wire logic word_err = (chk_mis || slip_err_q)
        && (sync_q == LPL_SYNC_WORDS);

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            err_flag_q <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            err_flag_q <= word_err || (err_flag_q && !err_clr);
            if (cnt_clr)
            begin
                cnt_q <= word_err ? LPL_CNT_W'(1) : '0;
            end
            else if (word_err && cnt_q != CNT_MAX)
            begin
                cnt_q <= cnt_q + LPL_CNT_W'(1);
            end
        end
    end

    assign test_error = err_flag_q;

    // Loopback FIFO; same clock, so any rate offset shows as over or underflow
    wire logic push = lb_cdr && rx_word_valid;
    wire logic pop = lb_cdr && lb_run_q;
    wire logic empty = (fill_q == '0);
    wire logic full = (fill_q == LB_FULL);
    wire logic do_push = push && !full;
    wire logic do_pop = pop && !empty;
    wire logic drift_ev = (push && full) || (pop && empty);

    always_ff @(posedge clock)
    begin
        if (do_push)
        begin
            lb_mem[wr_q] <= rx_word;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            fill_q <= '0;
            lb_run_q <= 1'b0;
            drift_q <= 1'b0;
        end
        else
        begin
            wr_q <= !lb_cdr ? '0 : wr_q + PW'(do_push);
            rd_q <= !lb_cdr ? '0 : rd_q + PW'(do_pop);
            fill_q <= !lb_cdr ? '0 : fill_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
            lb_run_q <= lb_cdr && (lb_run_q || fill_q >= LB_HALF);
            drift_q <= drift_ev || (drift_q && !drift_clr);
        end
    end

    // Transmit mux: loopback words, then test pattern, then user data
    wire logic [DATA_W-1:0] lb_word = do_pop ? lb_mem[rd_q] : '0;
    wire logic [DATA_W-1:0] tx_sel = lb_cdr ? lb_word
        : gen_en ? gen_word : tx_user_data;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_word_q <= '0;
            rx_user_q <= '0;
            rx_qual_q <= 1'b0;
        end
        else
        begin
            tx_word_q <= tx_sel;
            rx_user_q <= rx_word;
            rx_qual_q <= (lb_cdr || lb_eqf) ? rx_path_ready : rx_word_valid;
        end
    end

    assign tx_word = tx_word_q;
    assign rx_user_data = rx_user_q;
    assign rx_word_qualified = rx_qual_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    lb_onehot_a: assert property ($onehot0({lb_eqf, lb_eqn, lb_cdr}))
        else $error("more than one loopback active");
    tx_normal_a: assert property ((lb_sel == LPL_LB_NONE && !gen_en && !ctrl_wr)
        |=> tx_word == $past(tx_user_data))
        else $error("normal transmit path not used");
    cnt_step_a: assert property ((word_err && !cnt_clr && cnt_q != CNT_MAX)
        |=> cnt_q == $past(cnt_q) + LPL_CNT_W'(1))
        else $error("error counter did not step");
    cnt_sat_a: assert property ((cnt_q == CNT_MAX && !cnt_clr) |=> cnt_q == CNT_MAX)
        else $error("error counter wrapped");
    sticky_set_a: assert property (word_err |=> err_flag_q)
        else $error("sticky flag missed an error");
    sticky_hold_a: assert property ((err_flag_q && !err_clr) |=> err_flag_q)
        else $error("sticky flag dropped without clear");
    eqf_cdr_a: assert property (lb_eqf |-> (cdr_bypass && eq_bypass && tx_driver_en))
        else $error("far equalizer loopback path wrong");
    near_drv_a: assert property (lb_eqn |-> (!tx_driver_en && !cdr_bypass))
        else $error("near loopback left driver on");
    narrow_pat_a: assert property ((!wide || !pat_ok) |-> pat_eff == LPL_PAT_7)
        else $error("narrow bus used a long pattern");
    lb_tx_a: assert property ((lb_cdr && do_pop && !ctrl_wr)
        |=> tx_word == $past(lb_mem[rd_q]))
        else $error("loopback word not transmitted");
    slip_flag_a: assert property ((slip_err_q && sync_q == LPL_SYNC_WORDS)
        |=> err_flag_q)
        else $error("slip during a test not flagged");

endmodule

`default_nettype wire

// [design/lpl_pkg.sv]
package lpl_pkg;

    // Register byte addresses
    localparam logic [11:0] LPL_ADDR_CTRL = 12'h000;
    localparam logic [11:0] LPL_ADDR_STATUS = 12'h004;
    localparam logic [11:0] LPL_ADDR_ERRCNT = 12'h008;

    // Control register fields
    localparam int LPL_CTRL_GEN_BIT = 0;
    localparam int LPL_CTRL_CHK_BIT = 1;
    localparam int LPL_CTRL_PAT_LSB = 2;
    localparam int LPL_CTRL_LB_LSB = 5;
    localparam logic [6:0] LPL_CTRL_RESET = 7'h00;

    // Status register fields, write one to clear
    localparam int LPL_STAT_ERR_BIT = 0;
    localparam int LPL_STAT_DRIFT_BIT = 1;

    // Pattern select codes
    localparam logic [2:0] LPL_PAT_7 = 3'h0;
    localparam logic [2:0] LPL_PAT_9 = 3'h1;
    localparam logic [2:0] LPL_PAT_15 = 3'h2;
    localparam logic [2:0] LPL_PAT_23 = 3'h3;
    localparam logic [2:0] LPL_PAT_31 = 3'h4;

    // Loopback select codes
    localparam logic [1:0] LPL_LB_NONE = 2'h0;
    localparam logic [1:0] LPL_LB_EQ_FAR = 2'h1;
    localparam logic [1:0] LPL_LB_EQ_NEAR = 2'h2;
    localparam logic [1:0] LPL_LB_CDR_FAR = 2'h3;

    // Shift register geometry
    localparam int LPL_HIST_W = 31;
    localparam logic [30:0] LPL_SEED = 31'h7FFFFFFF;
    localparam int LPL_WIDE_MIN = 32;
    localparam logic [1:0] LPL_SYNC_WORDS = 2'h2;
    localparam int LPL_CNT_W = 16;

    // Polynomial length and inner tap: x^len + x^tap + 1
    function automatic logic [4:0] lpl_len(input logic [2:0] pat);
        case (pat)
            LPL_PAT_9: lpl_len = 5'h09;
            LPL_PAT_15: lpl_len = 5'h0F;
            LPL_PAT_23: lpl_len = 5'h17;
            LPL_PAT_31: lpl_len = 5'h1F;
            default: lpl_len = 5'h07;
        endcase
    endfunction

    function automatic logic [4:0] lpl_tap(input logic [2:0] pat);
        case (pat)
            LPL_PAT_9: lpl_tap = 5'h05;
            LPL_PAT_15: lpl_tap = 5'h0E;
            LPL_PAT_23: lpl_tap = 5'h12;
            LPL_PAT_31: lpl_tap = 5'h1C;
            default: lpl_tap = 5'h06;
        endcase
    endfunction

endpackage

// [design/lpl_prbs_word.sv]
`timescale 1ns/1ps
`default_nettype none

// One shift register, W bits per clock, bit 0 first on the line.
// In check mode the history is fed from received bits, so the checker
// locks by itself once one polynomial length has passed.
module lpl_prbs_word #(
    parameter int W = 40
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [2:0] pat,
    input wire logic run,
    input wire logic chk_mode,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout,
    output logic mismatch
);
    import lpl_pkg::*;

    logic [LPL_HIST_W-1:0] hist_q;
    logic [LPL_HIST_W-1:0] hist_d;
    logic [W-1:0] dout_q;
    logic [W-1:0] word_d;
    logic [W-1:0] mis_d;
    logic mismatch_q;
    wire logic [4:0] len = lpl_len(pat);
    wire logic [4:0] tap = lpl_tap(pat);

    always_comb
    begin
        logic fb;
        logic nb;
        fb = 1'b0;
        nb = 1'b0;
        hist_d = hist_q;
        for (int i = 0; i < W; i++)
        begin
            fb = hist_d[len - 5'h01] ^ hist_d[tap - 5'h01];
            nb = chk_mode ? din[i] : fb;
            word_d[i] = fb;
            mis_d[i] = din[i] ^ fb;
            hist_d = {hist_d[LPL_HIST_W-2:0], nb};
        end
    end

    // Seed is all ones: the all-zero state would lock the generator up
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            hist_q <= LPL_SEED;
            dout_q <= '0;
            mismatch_q <= 1'b0;
        end
        else
        begin
            if (run)
            begin
                hist_q <= hist_d;
            end
            dout_q <= run ? word_d : '0;
            mismatch_q <= run && chk_mode && (|mis_d);
        end
    end

    assign dout = dout_q;
    assign mismatch = mismatch_q;

    gen_zero_a: assert property (@(posedge clock) disable iff (!nrst)
        (!chk_mode && run) |=> (hist_q != '0))
        else $error("generator history fell to all zeros");

endmodule

`default_nettype wire

// [tb/lpl_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// Far end of the lane: returns words on the lane clock, optionally counting,
// corrupting one bit or shifting the word boundary by one bit.
module lpl_link_partner #(
    parameter int W = 40
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [W-1:0] tx_word,
    input wire logic [1:0] mode,
    input wire logic flip,
    input wire logic slip,
    input wire logic valid_en,
    input wire logic ready_en,
    output logic [W-1:0] rx_word,
    output logic rx_word_valid,
    output logic rx_path_ready,
    output logic rx_word_boundary_shift
);
    logic [W-1:0] prev_q;
    logic slipped_q;
    logic [W-1:0] echo;

    assign echo = (slipped_q | slip) ? {tx_word[W-2:0], prev_q[W-1]} : tx_word;
    assign rx_word_valid = valid_en;
    assign rx_path_ready = ready_en;
    assign rx_word_boundary_shift = slip;

    // Same clock as the transmit side, so no rate offset to absorb
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_word <= '0;
            prev_q <= '0;
            slipped_q <= 1'b0;
        end
        else
        begin
            prev_q <= tx_word;
            slipped_q <= (slipped_q | slip) & (mode != 2'h0);
            // Idle data is inverted each cycle so stale words never look valid
            if (!valid_en)
                rx_word <= ~rx_word;
            else if (mode == 2'h2)
                rx_word <= rx_word + 1'b1;
            else
                rx_word <= echo ^ W'(flip);
        end
    end
endmodule

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lpl_pkg::*;
    localparam int W = 40;
    logic clock, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, flip, slip, valid_en, ready_en, test_error, eq_bypass, cdr_bypass;
    logic [1:0] mode;
    logic [W-1:0] tx_user_data, tx_word, rx_word, rx_user_data, prv;
    logic rx_word_valid, rx_path_ready, rx_word_boundary_shift, rx_word_qualified;
    logic equalizer_far_loopback, equalizer_near_loopback, recovered_clock_far_loopback;
    logic tx_driver_en;
    int error_cnt, n_compared, ones;
    // Code 5 is unassigned and must fall back to the 7-stage pattern; it follows
    // the 7-stage run so the generator never starts from an all-zero low state
    logic [2:0] pats [6] = '{LPL_PAT_7, 3'h5, LPL_PAT_9, LPL_PAT_15, LPL_PAT_23, LPL_PAT_31};
    int lens [6] = '{7, 7, 9, 15, 23, 31};
    int taps [6] = '{6, 6, 5, 14, 18, 28};

    lpl_lane_test #(.DATA_W(W), .LB_DEPTH(8)) lpl_lane_test_inst (.clock, .nrst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_user_data,
        .tx_word, .rx_word, .rx_word_valid, .rx_path_ready, .rx_word_boundary_shift,
        .rx_user_data, .rx_word_qualified, .equalizer_far_loopback,
        .equalizer_near_loopback, .recovered_clock_far_loopback, .eq_bypass,
        .cdr_bypass, .tx_driver_en, .test_error);

    lpl_link_partner #(.W(W)) lpl_link_partner_inst (.clock, .nrst, .tx_word, .mode,
        .flip, .slip, .valid_en, .ready_en, .rx_word, .rx_word_valid, .rx_path_ready,
        .rx_word_boundary_shift);

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic conclude;
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [W-1:0] exp, input logic [W-1:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, W'(exp), W'(rd));
        chk({nm, " pslverr"}, '0, W'(er));
    endtask

    // Next word of the stream, bit 0 earliest: s[n] = s[n-len] ^ s[n-tap]
    function automatic logic [W-1:0] nxt(input logic [W-1:0] p, input int len, input int tap);
        logic [2*W-1:0] s;
        s = {{W{1'b0}}, p};
        for (int i = W; i < 2 * W; i++)
            s[i] = s[i-len] ^ s[i-tap];
        return s[2*W-1:W];
    endfunction

    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        nrst = 1'b0;
        {psel, penable, pwrite, flip, slip, ready_en} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        tx_user_data = 40'h00000000A5;
        mode = 2'h0;
        valid_en = 1'b1;
        error_cnt = 0;
        n_compared = 0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rd_chk(LPL_ADDR_CTRL, 32'h0, "ctrl reset");
        rd_chk(LPL_ADDR_STATUS, 32'h0, "status reset");
        rd_chk(LPL_ADDR_ERRCNT, 32'h0, "errcnt reset");
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped data", '0, W'(rd));
        chk("unmapped pslverr", 1, W'(er));
        @(negedge clock);
        chk("normal tx_word", tx_user_data, tx_word);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, LPL_ADDR_CTRL, 32'(i) << LPL_CTRL_LB_LSB);
            @(negedge clock);
            chk("eq far", W'(i == 1), W'(equalizer_far_loopback));
            chk("eq near", W'(i == 2), W'(equalizer_near_loopback));
            chk("cdr far", W'(i == 3), W'(recovered_clock_far_loopback));
            chk("bypass", W'(i == 1 ? 2'h3 : 2'h0), W'({eq_bypass, cdr_bypass}));
            chk("driver", W'(i != 2), W'(tx_driver_en));
            @(posedge clock);
            valid_en <= 1'b0;
            ready_en <= 1'b1;
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk("qualified", W'(i == 1 || i == 3), W'(rx_word_qualified));
            rd_chk(LPL_ADDR_CTRL, 32'(i) << LPL_CTRL_LB_LSB, "ctrl readback");
        end
        @(posedge clock);
        mode <= 2'h2;
        valid_en <= 1'b1;
        repeat (20) @(posedge clock);
        @(negedge clock);
        prv = tx_word;
        chk("rx_user_data", rx_word - 1'b1, rx_user_data);
        @(negedge clock);
        chk("fifo word", prv + 1'b1, tx_word);
        rd_chk(LPL_ADDR_STATUS, 32'h0, "drift");
        @(posedge clock);
        mode <= 2'h1;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, LPL_ADDR_CTRL, 32'h0);
            apb(1'b1, LPL_ADDR_STATUS, 32'h3);
            apb(1'b1, LPL_ADDR_ERRCNT, 32'h0);
            // Generator first so the checker never locks onto idle words
            apb(1'b1, LPL_ADDR_CTRL, 32'h1 | (32'(pats[i]) << LPL_CTRL_PAT_LSB));
            apb(1'b1, LPL_ADDR_CTRL, 32'h3 | (32'(pats[i]) << LPL_CTRL_PAT_LSB));
            repeat (30) @(posedge clock);
            ones = 0;
            @(negedge clock);
            prv = tx_word;
            repeat (i == 0 ? 127 : 20)
            begin
                @(negedge clock);
                chk("prbs word", nxt(prv, lens[i], taps[i]), tx_word);
                ones += $countones(tx_word);
                prv = tx_word;
            end
            if (i == 0)
                chk("ones", 2560, W'(ones));
            rd_chk(LPL_ADDR_ERRCNT, 32'h0, "clean errcnt");
            chk("clean error", '0, W'(test_error));
        end
        @(posedge clock);
        flip <= 1'b1;
        @(posedge clock);
        flip <= 1'b0;
        repeat (6) @(posedge clock);
        rd_chk(LPL_ADDR_STATUS, 32'h1, "status error");
        rd_chk(LPL_ADDR_ERRCNT, 32'h1, "errcnt counted");
        repeat (10) @(posedge clock);
        chk("sticky", 1, W'(test_error));
        apb(1'b1, LPL_ADDR_STATUS, 32'h1);
        apb(1'b1, LPL_ADDR_ERRCNT, 32'h0);
        @(negedge clock);
        chk("cleared", '0, W'(test_error));
        rd_chk(LPL_ADDR_ERRCNT, 32'h0, "errcnt cleared");
        @(posedge clock);
        slip <= 1'b1;
        @(posedge clock);
        slip <= 1'b0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk("slip error", 1, W'(test_error));
        // Reset in mid-run must drop every sticky and transmit state
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        chk("reset error", '0, W'(test_error));
        chk("reset tx_word", '0, tx_word);
        nrst <= 1'b1;
        rd_chk(LPL_ADDR_CTRL, 32'h0, "ctrl after reset");
        rd_chk(LPL_ADDR_ERRCNT, 32'h0, "errcnt after reset");
        @(negedge clock);
        chk("tx after reset", tx_user_data, tx_word);
        conclude();
    end
endmodule

`default_nettype wire
